// file: rtl/lsbx_exec.sv
// Purpose: Executes loads, stores, flash access, I/O, stack, shift and bit operations.
// Assumes: Memories answer reads in the same cycle as the request; inputs are synchronous.
// Notes: A load writes its register at the next edge; later operands are forwarded.
// Contract
// RULE1: Indirect load, plain or post-increment pointer, completes in one cycle.
// RULE2: Pre-decrement load lowers pointer first, reads the new address, two cycles.
// RULE3: Displacement load reads pointer plus q, pointer unchanged, two cycles.
// RULE4: Direct store writes a register to the instruction address in two cycles.
// RULE5: Indirect store, plain or post-increment pointer, takes one cycle.
// RULE6: Pre-decrement store lowers pointer first, then writes, two cycles.
// RULE7: Displacement store writes to pointer plus q, pointer kept, two cycles.
// RULE8: Flash read via third pointer into a register, optional increment, three cycles.
// RULE9: Far flash read uses extension register joined with third pointer, three cycles.
// RULE10: Flash word write stores the lowest register pair; increment form adds two.
// RULE11: I/O read or write of a working register takes one cycle.
// RULE12: Push takes one cycle, pop takes two cycles.
// RULE13: Left rotate or shift moves bits up; carry from bit 7; updates Z C N V H.
// RULE14: Right rotate or shift moves bits down; carry from bit 0; updates Z C N V.
// RULE15: Any status flag is set or cleared by bit index in one cycle.
// RULE16: Register bit copies to T, and T copies to a register bit, one cycle.
// RULE17: An I/O register bit is set or cleared in one cycle, flags untouched.
// RULE18: Cycle counts hold only for internal memory; external memory may stall.
// RULE19: Arithmetic right shift keeps bit 7, carry from bit 0, updates Z C N V.
// RULE20: No-op, break, sleep and watchdog reset take one cycle, flags unchanged.
`default_nettype none
`include "lsbx_consts.svh"
module lsbx_exec (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Decoded instruction.
  input wire logic cmd_valid,
  input wire lsbx_pkg::lsbx_op_t cmd_op,
  input wire lsbx_pkg::lsbx_amode_t cmd_mode,
  input wire lsbx_pkg::lsbx_ptr_t cmd_ptr,
  input wire logic [4:0] cmd_rd,
  input wire logic [4:0] cmd_rr,
  input wire logic [5:0] cmd_q,
  input wire logic [15:0] cmd_k,
  input wire logic [5:0] cmd_a,
  input wire logic [2:0] cmd_bit,
  output logic cmd_ready,
  // Data memory and stack.
  output logic [15:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic dm_we,
  output logic dm_re,
  input wire logic [7:0] dm_rdata,
  input wire logic dm_wait,
  // Program flash.
  output logic [23:0] fl_addr,
  output logic [15:0] fl_wdata,
  output logic fl_we,
  output logic fl_re,
  input wire logic [7:0] fl_rdata,
  input wire logic fl_busy,
  // I/O register space.
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re,
  output logic io_flag_set_op,
  output logic io_flag_clear_op,
  output logic [2:0] io_bit,
  input wire logic [7:0] io_rdata,
  // Core control requests.
  output logic sleep_req,
  output logic break_req,
  output logic wdr_req,
  // Visible state.
  input wire logic [4:0] dbg_sel,
  output logic [7:0] dbg_val,
  output logic [7:0] flag_register,
  output logic [15:0] stack_ptr,
  output logic [7:0] high_pointer_extension
);
  lsbx_pkg::lsbx_state_t st_ff;
  lsbx_pkg::lsbx_state_t nxt_st;
  logic [7:0] pdata;
  always_comb
  begin
    unique case (st_ff.pend_src)
      lsbx_pkg::src_io: pdata = io_rdata;
      lsbx_pkg::src_fl: pdata = fl_rdata;
      default: pdata = dm_rdata;
    endcase
  end
  // Register read with forwarding of the load that lands at this edge.
  function automatic logic [7:0] rv(input logic [4:0] idx);
    rv = (st_ff.pend && st_ff.pend_dst == idx) ? pdata : st_ff.regs[idx];
  endfunction
  always_comb
  begin
    logic [4:0] lo;
    logic [15:0] pv;
    logic [15:0] ea;
    logic [7:0] op;
    logic [7:0] res;
    logic cy;
    logic take;
    lo = 5'h00;
    pv = 16'h0000;
    ea = 16'h0000;
    op = 8'h00;
    res = 8'h00;
    cy = 1'b0;
    take = 1'b0;
    nxt_st = st_ff;
    nxt_st.dm_we = 1'b0;
    nxt_st.dm_re = 1'b0;
    nxt_st.fl_we = 1'b0;
    nxt_st.fl_re = 1'b0;
    nxt_st.io_we = 1'b0;
    nxt_st.io_re = 1'b0;
    nxt_st.io_flag_set_op = 1'b0;
    nxt_st.io_flag_clear_op = 1'b0;
    nxt_st.sleep = 1'b0;
    nxt_st.brk = 1'b0;
    nxt_st.wdr = 1'b0;
    nxt_st.pend = 1'b0;
    if (st_ff.pend)
    begin
      nxt_st.regs[st_ff.pend_dst] = pdata;
    end
    nxt_st.cnt = (st_ff.cnt != 2'h0) ? st_ff.cnt - 2'h1 : 2'h0;
    nxt_st.fl_wait = st_ff.fl_wait && fl_busy; // RULE10
    lo = `LSBX_PTR_BASE + {2'h0, cmd_ptr, 1'b0};
    pv = {rv(lo + 5'h01), rv(lo)};
    op = rv(cmd_rd);
    take = st_ff.ready && cmd_valid;
    if (take)
    begin
      unique case (cmd_op)
        lsbx_pkg::memory_read_op, lsbx_pkg::memory_write_op:
        begin
          ea = (cmd_mode == lsbx_pkg::addr_pre_dec) ? pv - 16'h0001 : pv;
          nxt_st.dm_addr = ea;
          if (cmd_op == lsbx_pkg::memory_read_op)
          begin
            nxt_st.dm_re = 1'b1; // RULE1
            nxt_st.pend = 1'b1;
            nxt_st.pend_dst = cmd_rd;
            nxt_st.pend_src = lsbx_pkg::src_dm;
          end
          else
          begin
            nxt_st.dm_we = 1'b1; // RULE5
            nxt_st.dm_wdata = rv(cmd_rr);
          end
          if (cmd_mode == lsbx_pkg::addr_post_inc)
          begin
            {nxt_st.regs[lo + 5'h01], nxt_st.regs[lo]} = pv + 16'h0001; // RULE1 RULE5
          end
          if (cmd_mode == lsbx_pkg::addr_pre_dec)
          begin
            {nxt_st.regs[lo + 5'h01], nxt_st.regs[lo]} = ea; // RULE2 RULE6
            nxt_st.cnt = `LSBX_EXTRA_ONE;
          end
        end
        lsbx_pkg::offset_memory_read_op:
        begin
          nxt_st.dm_addr = pv + {10'h000, cmd_q}; // RULE3
          nxt_st.dm_re = 1'b1;
          nxt_st.pend = 1'b1;
          nxt_st.pend_dst = cmd_rd;
          nxt_st.pend_src = lsbx_pkg::src_dm;
          nxt_st.cnt = `LSBX_EXTRA_ONE;
        end
        lsbx_pkg::offset_memory_write_op, lsbx_pkg::direct_memory_write_op:
        begin
          nxt_st.dm_addr = (cmd_op == lsbx_pkg::direct_memory_write_op) ? cmd_k : pv + {10'h000, cmd_q}; // RULE4 RULE7
          nxt_st.dm_we = 1'b1;
          nxt_st.dm_wdata = rv(cmd_rr);
          nxt_st.cnt = `LSBX_EXTRA_ONE;
        end
        lsbx_pkg::flash_read_op, lsbx_pkg::far_flash_read_op:
        begin
          nxt_st.fl_addr = {(cmd_op == lsbx_pkg::far_flash_read_op) ? st_ff.ext : 8'h00, pv}; // RULE8 RULE9
          nxt_st.fl_re = 1'b1;
          nxt_st.pend = 1'b1;
          nxt_st.pend_dst = cmd_rd;
          nxt_st.pend_src = lsbx_pkg::src_fl;
          nxt_st.cnt = `LSBX_EXTRA_FLASH;
          if (cmd_mode == lsbx_pkg::addr_post_inc)
          begin
            {nxt_st.regs[lo + 5'h01], nxt_st.regs[lo]} = pv + 16'h0001;
          end
        end
        lsbx_pkg::flash_word_write_op:
        begin
          nxt_st.fl_addr = {st_ff.ext, pv}; // RULE10
          nxt_st.fl_wdata = {rv(5'h01), rv(5'h00)};
          nxt_st.fl_we = 1'b1;
          nxt_st.fl_wait = 1'b1;
          if (cmd_mode == lsbx_pkg::addr_post_inc)
          begin
            {nxt_st.regs[lo + 5'h01], nxt_st.regs[lo]} = pv + `LSBX_FLASH_STEP;
          end
        end
        lsbx_pkg::io_in_op, lsbx_pkg::io_out_op:
        begin
          nxt_st.io_addr = cmd_a; // RULE11
          nxt_st.io_re = (cmd_op == lsbx_pkg::io_in_op);
          nxt_st.io_we = (cmd_op == lsbx_pkg::io_out_op);
          nxt_st.io_wdata = rv(cmd_rr);
          nxt_st.pend = (cmd_op == lsbx_pkg::io_in_op);
          nxt_st.pend_dst = cmd_rd;
          nxt_st.pend_src = lsbx_pkg::src_io;
        end
        lsbx_pkg::push_op:
        begin
          nxt_st.dm_addr = st_ff.sp; // RULE12
          nxt_st.dm_we = 1'b1;
          nxt_st.dm_wdata = rv(cmd_rr);
          nxt_st.sp = st_ff.sp - 16'h0001;
        end
        lsbx_pkg::pop_op:
        begin
          nxt_st.dm_addr = st_ff.sp + 16'h0001; // RULE12
          nxt_st.sp = st_ff.sp + 16'h0001;
          nxt_st.dm_re = 1'b1;
          nxt_st.pend = 1'b1;
          nxt_st.pend_dst = cmd_rd;
          nxt_st.pend_src = lsbx_pkg::src_dm;
          nxt_st.cnt = `LSBX_EXTRA_ONE;
        end
        lsbx_pkg::left_shift_zero_fill, lsbx_pkg::rotate_left_carry:
        begin
          cy = (cmd_op == lsbx_pkg::rotate_left_carry) ? st_ff.flags[`LSBX_FLAG_C] : 1'b0;
          res = {op[6:0], cy}; // RULE13
          nxt_st.regs[cmd_rd] = res;
          nxt_st.flags[`LSBX_FLAG_C] = op[7];
          nxt_st.flags[`LSBX_FLAG_Z] = (res == 8'h00);
          nxt_st.flags[`LSBX_FLAG_N] = res[7];
          nxt_st.flags[`LSBX_FLAG_V] = res[7] ^ op[7];
          nxt_st.flags[`LSBX_FLAG_H] = op[3];
        end
        lsbx_pkg::right_shift_zero_fill, lsbx_pkg::rotate_right_carry, lsbx_pkg::sign_keeping_right_shift:
        begin
          unique case (cmd_op)
            lsbx_pkg::rotate_right_carry: cy = st_ff.flags[`LSBX_FLAG_C]; // RULE14
            lsbx_pkg::sign_keeping_right_shift: cy = op[7]; // RULE19
            default: cy = 1'b0;
          endcase
          res = {cy, op[7:1]};
          nxt_st.regs[cmd_rd] = res;
          nxt_st.flags[`LSBX_FLAG_C] = op[0];
          nxt_st.flags[`LSBX_FLAG_Z] = (res == 8'h00);
          nxt_st.flags[`LSBX_FLAG_N] = res[7];
          nxt_st.flags[`LSBX_FLAG_V] = res[7] ^ op[0];
        end
        lsbx_pkg::flag_set_op, lsbx_pkg::flag_clear_op:
        begin
          nxt_st.flags[cmd_bit] = (cmd_op == lsbx_pkg::flag_set_op); // RULE15
        end
        lsbx_pkg::io_bit_set_op, lsbx_pkg::io_bit_clear_op:
        begin
          nxt_st.io_addr = cmd_a; // RULE17
          nxt_st.io_bit = cmd_bit;
          nxt_st.io_flag_set_op = (cmd_op == lsbx_pkg::io_bit_set_op);
          nxt_st.io_flag_clear_op = (cmd_op == lsbx_pkg::io_bit_clear_op);
        end
        lsbx_pkg::copy_bit_to_transfer_flag:
        begin
          res = rv(cmd_rr);
          nxt_st.flags[`LSBX_FLAG_T] = res[cmd_bit]; // RULE16
        end
        lsbx_pkg::copy_transfer_flag_to_bit:
        begin
          nxt_st.regs[cmd_rd][cmd_bit] = st_ff.flags[`LSBX_FLAG_T]; // RULE16
        end
        lsbx_pkg::extension_load_op:
        begin
          nxt_st.ext = rv(cmd_rr);
        end
        lsbx_pkg::break_op:
        begin
          nxt_st.brk = 1'b1; // RULE20
        end
        lsbx_pkg::sleep_op:
        begin
          nxt_st.sleep = 1'b1; // RULE20
        end
        lsbx_pkg::watchdog_op:
        begin
          nxt_st.wdr = 1'b1; // RULE20
        end
        default: nxt_st.cnt = 2'h0;
      endcase
    end
    nxt_st.ready = (nxt_st.cnt == 2'h0) && !nxt_st.fl_wait;
    nxt_st.dbg = nxt_st.regs[dbg_sel];
    // External memory holds the whole unit until it answers.
    if (dm_wait)
    begin
      nxt_st = st_ff; // RULE18
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
      st_ff.sp <= `LSBX_SP_RST;
      st_ff.ready <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  assign cmd_ready = st_ff.ready;
  assign dm_addr = st_ff.dm_addr;
  assign dm_wdata = st_ff.dm_wdata;
  assign dm_we = st_ff.dm_we;
  assign dm_re = st_ff.dm_re;
  assign fl_addr = st_ff.fl_addr;
  assign fl_wdata = st_ff.fl_wdata;
  assign fl_we = st_ff.fl_we;
  assign fl_re = st_ff.fl_re;
  assign io_addr = st_ff.io_addr;
  assign io_wdata = st_ff.io_wdata;
  assign io_we = st_ff.io_we;
  assign io_re = st_ff.io_re;
  assign io_flag_set_op = st_ff.io_flag_set_op;
  assign io_flag_clear_op = st_ff.io_flag_clear_op;
  assign io_bit = st_ff.io_bit;
  assign sleep_req = st_ff.sleep;
  assign break_req = st_ff.brk;
  assign wdr_req = st_ff.wdr;
  assign dbg_val = st_ff.dbg;
  assign flag_register = st_ff.flags;
  assign stack_ptr = st_ff.sp;
  assign high_pointer_extension = st_ff.ext;
endmodule
`default_nettype wire

// file: common/lsbx_consts.svh
// Purpose: Constants for the load/store/bit execution unit.
// Assumes: Flag positions follow the status byte layout used by the core.
// Notes: Extra-cycle counts are cycles the unit refuses work after a take.
`ifndef LSBX_CONSTS_SVH
`define LSBX_CONSTS_SVH
`define LSBX_FLAG_C 3'h0
`define LSBX_FLAG_Z 3'h1
`define LSBX_FLAG_N 3'h2
`define LSBX_FLAG_V 3'h3
`define LSBX_FLAG_S 3'h4
`define LSBX_FLAG_H 3'h5
`define LSBX_FLAG_T 3'h6
`define LSBX_FLAG_I 3'h7
`define LSBX_PTR_BASE 5'h1A
`define LSBX_SP_RST 16'h0FFF
`define LSBX_EXTRA_ONE 2'h1
`define LSBX_EXTRA_FLASH 2'h2
`define LSBX_FLASH_STEP 16'h0002
`endif

// file: common/lsbx_pkg.sv
// Purpose: Types for the load/store/bit execution unit.
// Assumes: The instruction decoder ahead of this unit produces op_t codes.
// Notes: The whole unit state is one packed struct.
`default_nettype none
package lsbx_pkg;
  typedef enum logic [4:0] {
    nop_op, break_op, sleep_op, watchdog_op,
    memory_read_op, offset_memory_read_op, memory_write_op, offset_memory_write_op,
    direct_memory_write_op, flash_read_op, far_flash_read_op, flash_word_write_op,
    io_in_op, io_out_op, push_op, pop_op,
    left_shift_zero_fill, right_shift_zero_fill, rotate_left_carry, rotate_right_carry,
    sign_keeping_right_shift, flag_set_op, flag_clear_op, io_bit_set_op,
    io_bit_clear_op, copy_bit_to_transfer_flag, copy_transfer_flag_to_bit, extension_load_op
  } lsbx_op_t;
  typedef enum logic [1:0] {addr_plain, addr_post_inc, addr_pre_dec} lsbx_amode_t;
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} lsbx_ptr_t;
  typedef enum logic [1:0] {src_dm, src_io, src_fl} lsbx_src_t;
  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [7:0] flags;
    logic [15:0] sp;
    logic [7:0] ext;
    logic [1:0] cnt;
    logic fl_wait;
    logic ready;
    logic pend;
    logic [4:0] pend_dst;
    lsbx_src_t pend_src;
    logic [15:0] dm_addr;
    logic [7:0] dm_wdata;
    logic dm_we;
    logic dm_re;
    logic [23:0] fl_addr;
    logic [15:0] fl_wdata;
    logic fl_we;
    logic fl_re;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic io_we;
    logic io_re;
    logic io_flag_set_op;
    logic io_flag_clear_op;
    logic [2:0] io_bit;
    logic sleep;
    logic brk;
    logic wdr;
    logic [7:0] dbg;
  } lsbx_state_t;
endpackage
`default_nettype wire

// file: bench/lsbx_exec_props.sv
// Purpose: Port checks on command timing and side effects of the execution unit.
// Assumes: Bound to lsbx_exec; dm_wait freezes the unit.
// Notes: Each check starts at the edge that takes a command.
`default_nettype none
module lsbx_exec_props (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Command port.
  input wire logic cmd_valid,
  input wire lsbx_pkg::lsbx_op_t cmd_op,
  input wire lsbx_pkg::lsbx_amode_t cmd_mode,
  input wire logic [15:0] cmd_k,
  input wire logic [5:0] cmd_a,
  input wire logic [2:0] cmd_bit,
  input wire logic cmd_ready,
  // Far side.
  input wire logic [15:0] dm_addr,
  input wire logic dm_we,
  input wire logic dm_re,
  input wire logic dm_wait,
  input wire logic fl_re,
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic io_flag_set_op,
  input wire logic [2:0] io_bit,
  // State.
  input wire logic [7:0] flag_register,
  input wire logic [15:0] stack_ptr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  assign take = cmd_valid && cmd_ready && !dm_wait;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_gap1;
    !cmd_ready ##1 cmd_ready;
  endsequence
  sequence s_gap2;
    fl_re && !cmd_ready ##1 s_gap1;
  endsequence
  load_one_cycle_a:
    assert property (take && cmd_op == lsbx_pkg::memory_read_op && cmd_mode != lsbx_pkg::addr_pre_dec
      |=> dm_re && cmd_ready) else $error("single cycle load refused next command");
  two_cycle_ops_a:
    assert property (take && ((cmd_op inside {lsbx_pkg::memory_read_op, lsbx_pkg::memory_write_op}
      && cmd_mode == lsbx_pkg::addr_pre_dec) || cmd_op inside {lsbx_pkg::offset_memory_read_op,
      lsbx_pkg::offset_memory_write_op, lsbx_pkg::direct_memory_write_op, lsbx_pkg::pop_op})
      |=> s_gap1) else $error("two cycle op length wrong");
  flash_read_gap_a:
    assert property (take && cmd_op inside {lsbx_pkg::flash_read_op, lsbx_pkg::far_flash_read_op}
      |=> s_gap2) else $error("flash read length wrong");
  direct_store_a:
    assert property (take && cmd_op == lsbx_pkg::direct_memory_write_op
      |=> dm_we && dm_addr == $past(cmd_k)) else $error("direct store address wrong");
  push_stack_a:
    assert property (take && cmd_op == lsbx_pkg::push_op |=> dm_we && cmd_ready
      && dm_addr == $past(stack_ptr) && stack_ptr == $past(stack_ptr) - 16'h0001) else $error("push wrong");
  io_write_a:
    assert property (take && cmd_op == lsbx_pkg::io_out_op
      |=> io_we && cmd_ready && io_addr == $past(cmd_a)) else $error("io write wrong");
  io_bit_flags_a:
    assert property (take && cmd_op == lsbx_pkg::io_bit_set_op
      |=> io_flag_set_op && io_bit == $past(cmd_bit) && $stable(flag_register)) else $error("io bit set wrong");
  ctrl_flags_a:
    assert property (take && cmd_op inside {lsbx_pkg::nop_op, lsbx_pkg::break_op, lsbx_pkg::sleep_op,
      lsbx_pkg::watchdog_op} |=> cmd_ready && $stable(flag_register)) else $error("control op wrong");
  flag_set_a:
    assert property (take && cmd_op == lsbx_pkg::flag_set_op
      |=> flag_register[$past(cmd_bit)]) else $error("flag not set");
endmodule
`default_nettype wire

// file: bench/lsbx_mem_model.sv
// Purpose: Behavioural data memory, I/O space and program flash.
// Assumes: Data memory is 256 bytes mirrored; byte i starts as i ^ 8'h5A.
// Notes: Outside a read window the data lines show the inverse of the byte.
`default_nettype none
module lsbx_mem_model (
  // Clock.
  input wire logic core_clk,
  // Data memory.
  input wire logic [15:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  input wire logic dm_re,
  output logic [7:0] dm_rdata,
  // Program flash.
  input wire logic [23:0] fl_addr,
  input wire logic fl_we,
  input wire logic fl_re,
  output logic [7:0] fl_rdata,
  output logic fl_busy,
  // I/O space.
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic io_flag_set_op,
  input wire logic io_flag_clear_op,
  input wire logic [2:0] io_bit,
  output logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] io_mem [64];
  logic [7:0] fb;
  logic [1:0] busy_cnt = 2'h0;
  logic dre, fre, ire;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5A;
    foreach (io_mem[i]) io_mem[i] = 8'h00;
  end
  always @(posedge core_clk)
  begin
    dre <= dm_re;
    fre <= fl_re;
    ire <= io_re;
    if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
    if (io_we) io_mem[io_addr] <= io_wdata;
    if (io_flag_set_op) io_mem[io_addr][io_bit] <= 1'b1;
    if (io_flag_clear_op) io_mem[io_addr][io_bit] <= 1'b0;
    busy_cnt <= fl_we ? 2'h3 : busy_cnt - {1'b0, busy_cnt != 2'h0};
  end
  assign fb = fl_addr[7:0] ^ fl_addr[23:16] ^ 8'hC3;
  // Busy rises with the write strobe itself, as the unit samples it in that cycle.
  assign fl_busy = fl_we || busy_cnt != 2'h0;
  assign dm_rdata = (dm_re || dre) ? mem[dm_addr[7:0]] : ~mem[dm_addr[7:0]];
  assign fl_rdata = (fl_re || fre) ? fb : ~fb;
  assign io_rdata = (io_re || ire) ? io_mem[io_addr] : ~io_mem[io_addr];
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the load/store/bit execution unit.
// Assumes: Memory byte i is i ^ 8'h5A; flash byte is addr[7:0] ^ addr[23:16] ^ 8'hC3.
// Notes: Registers are read back through the debug port.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, cmd_valid, cmd_ready, dm_we, dm_re, dm_wait, fl_we, fl_re, fl_busy;
  logic io_we, io_re, io_flag_set_op, io_flag_clear_op, c, slp, brk, wdr;
  lsbx_pkg::lsbx_op_t cmd_op;
  lsbx_pkg::lsbx_amode_t cmd_mode;
  lsbx_pkg::lsbx_ptr_t cmd_ptr;
  logic [4:0] cmd_rd, dbg_sel;
  logic [5:0] cmd_q, io_addr;
  logic [15:0] cmd_k, dm_addr, stack_ptr;
  logic [2:0] cmd_bit, io_bit;
  logic [7:0] dm_wdata, dm_rdata, fl_rdata, io_wdata, io_rdata, dbg_val, flag_register, ext_val, v, f, n;
  logic [23:0] fl_addr;
  logic [15:0] fl_wdata;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  lsbx_exec dut_u (.core_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_mode, .cmd_ptr, .cmd_rd, .cmd_rr(cmd_rd),
    .cmd_q, .cmd_k, .cmd_a(cmd_q), .cmd_bit, .cmd_ready, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata,
    .dm_wait, .fl_addr, .fl_wdata, .fl_we, .fl_re, .fl_rdata, .fl_busy, .io_addr, .io_wdata, .io_we,
    .io_re, .io_flag_set_op, .io_flag_clear_op, .io_bit, .io_rdata, .sleep_req(slp), .break_req(brk), .wdr_req(wdr), .dbg_sel,
    .dbg_val, .flag_register, .stack_ptr, .high_pointer_extension(ext_val));
  lsbx_mem_model mem_u (.core_clk, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .fl_addr, .fl_we, .fl_re,
    .fl_rdata, .fl_busy, .io_addr, .io_wdata, .io_we, .io_re, .io_flag_set_op, .io_flag_clear_op, .io_bit, .io_rdata);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_reg(input logic [4:0] r, input logic [7:0] e);
    dbg_sel = r;
    repeat (3) @(negedge core_clk);
    chk($sformatf("reg %0d", r), {8'h00, e}, {8'h00, dbg_val});
  endtask
  // Waits for the unit to be free, offers one command and withdraws it after the take.
  task automatic op(input lsbx_pkg::lsbx_op_t o, input logic [4:0] r = 5'h00, input logic [5:0] q = 6'h00,
      input lsbx_pkg::lsbx_amode_t m = lsbx_pkg::addr_plain, input logic [2:0] b = 3'h0);
    int k;
    k = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && k < 50)
    begin
      @(negedge core_clk);
      k++;
    end
    cmd_op = o;
    cmd_rd = r;
    cmd_q = q;
    cmd_k = {10'h000, q};
    cmd_mode = m;
    cmd_bit = b;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  initial
  begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    dm_wait = 1'b0;
    dbg_sel = 5'h00;
    cmd_op = lsbx_pkg::nop_op;
    cmd_mode = lsbx_pkg::addr_plain;
    cmd_ptr = lsbx_pkg::ptr_z;
    cmd_rd = 5'h00;
    cmd_q = 6'h00;
    cmd_k = 16'h0000;
    cmd_bit = 3'h0;
    f = 8'h00;
    repeat (10) @(negedge core_clk);
    chk("ready", 16'h0001, {15'h0000, cmd_ready});
    chk("sp", 16'h0FFF, stack_ptr);
    sys_rst = 1'b0;
    op(lsbx_pkg::memory_read_op, 5'h05, 6'h00, lsbx_pkg::addr_post_inc);
    chk_reg(5'h1E, 8'h01);
    op(lsbx_pkg::memory_read_op, 5'h06, 6'h00, lsbx_pkg::addr_pre_dec);
    chk_reg(5'h06, 8'h5A);
    op(lsbx_pkg::offset_memory_read_op, 5'h07, 6'h05);
    chk_reg(5'h07, 8'h5F);
    chk_reg(5'h1E, 8'h00);
    cmd_ptr = lsbx_pkg::ptr_y;
    op(lsbx_pkg::offset_memory_write_op, 5'h07, 6'h09);
    cmd_ptr = lsbx_pkg::ptr_x;
    op(lsbx_pkg::memory_write_op, 5'h07, 6'h00, lsbx_pkg::addr_post_inc);
    op(lsbx_pkg::memory_write_op, 5'h05, 6'h00, lsbx_pkg::addr_pre_dec);
    cmd_ptr = lsbx_pkg::ptr_z;
    op(lsbx_pkg::direct_memory_write_op, 5'h07, 6'h20);
    op(lsbx_pkg::offset_memory_read_op, 5'h08, 6'h09);
    op(lsbx_pkg::offset_memory_read_op, 5'h09, 6'h20);
    op(lsbx_pkg::memory_read_op, 5'h0A);
    chk_reg(5'h08, 8'h5F);
    chk_reg(5'h09, 8'h5F);
    chk_reg(5'h0A, 8'h5A);
    chk_reg(5'h1A, 8'h00);
    op(lsbx_pkg::memory_read_op, 5'h10);
    dm_wait = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("held read", 16'h0001, {15'h0000, dm_re});
    dm_wait = 1'b0;
    chk_reg(5'h10, 8'h5A);
    op(lsbx_pkg::push_op, 5'h07);
    chk("sp", 16'h0FFE, stack_ptr);
    op(lsbx_pkg::pop_op, 5'h0B);
    chk("sp", 16'h0FFF, stack_ptr);
    chk_reg(5'h0B, 8'h5F);
    op(lsbx_pkg::io_out_op, 5'h07, 6'h03);
    op(lsbx_pkg::io_bit_set_op, 5'h00, 6'h03, lsbx_pkg::addr_plain, 3'h7);
    op(lsbx_pkg::io_bit_clear_op, 5'h00, 6'h03);
    op(lsbx_pkg::io_in_op, 5'h0C, 6'h03);
    chk_reg(5'h0C, 8'hDE);
    for (int i = 0; i < 8; i++)
    begin
      op(lsbx_pkg::flag_set_op, 5'h00, 6'h00, lsbx_pkg::addr_plain, 3'(i));
      chk("flags", {8'h00, 8'(8'hFF >> (7 - i))}, {8'h00, flag_register});
    end
    for (int i = 0; i < 4; i++)
    begin
      op(lsbx_pkg::lsbx_op_t'(i));
      chk("flags", 16'h00FF, {8'h00, flag_register});
      chk("ctrl req", {13'h0000, i == 2, i == 1, i == 3}, {13'h0000, slp, brk, wdr});
    end
    for (int i = 0; i < 8; i++)
    begin
      op(lsbx_pkg::flag_clear_op, 5'h00, 6'h00, lsbx_pkg::addr_plain, 3'(i));
      chk("flags", {8'h00, 8'(8'hFF << (i + 1))}, {8'h00, flag_register});
    end
    v = 8'h5F;
    // Codes 16 to 20 are the five shift and rotate operations.
    for (int i = 16; i < 21; i++)
    begin
      c = (i == 16 || i == 18);
      // Carry is set ahead of the carry-using shifts so that a lost carry input shows.
      if (i > 17)
      begin
        op(lsbx_pkg::flag_set_op, 5'h00, 6'h00, lsbx_pkg::addr_plain, 3'h0);
        f[0] = 1'b1;
      end
      case (i)
        16: n = {v[6:0], 1'b0};
        17: n = {1'b0, v[7:1]};
        18: n = {v[6:0], f[0]};
        19: n = {f[0], v[7:1]};
        default: n = {v[7], v[7:1]};
      endcase
      f[0] = c ? v[7] : v[0];
      f[1] = n == 8'h00;
      f[2] = n[7];
      f[3] = n[7] ^ f[0];
      f[5] = c ? v[3] : f[5];
      op(lsbx_pkg::lsbx_op_t'(i), 5'h07);
      chk("flags", {8'h00, f}, {8'h00, flag_register});
      chk_reg(5'h07, n);
      v = n;
    end
    for (int i = 0; i < 8; i++)
    begin
      op(lsbx_pkg::copy_bit_to_transfer_flag, 5'h07, 6'h00, lsbx_pkg::addr_plain, 3'(i));
      chk("flags", {8'h00, f[7], v[i], f[5:0]}, {8'h00, flag_register});
      op(lsbx_pkg::copy_transfer_flag_to_bit, 5'h0D, 6'h00, lsbx_pkg::addr_plain, 3'(i));
    end
    chk_reg(5'h0D, v);
    op(lsbx_pkg::flash_read_op, 5'h00, 6'h00, lsbx_pkg::addr_post_inc);
    chk_reg(5'h00, 8'hC3);
    op(lsbx_pkg::extension_load_op, 5'h07);
    op(lsbx_pkg::far_flash_read_op, 5'h01, 6'h00, lsbx_pkg::addr_post_inc);
    chk_reg(5'h01, 8'h01 ^ v ^ 8'hC3);
    op(lsbx_pkg::flash_word_write_op, 5'h00, 6'h00, lsbx_pkg::addr_post_inc);
    chk("fl_wdata", {8'h01 ^ v ^ 8'hC3, 8'hC3}, fl_wdata);
    chk("ready", 16'h0000, {15'h0000, cmd_ready});
    chk_reg(5'h1E, 8'h04);
    op(lsbx_pkg::nop_op);
    tally_and_finish;
  end
endmodule
bind lsbx_exec lsbx_exec_props chk_u (.core_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_mode, .cmd_k, .cmd_a,
  .cmd_bit, .cmd_ready, .dm_addr, .dm_we, .dm_re, .dm_wait, .fl_re, .io_addr, .io_we, .io_flag_set_op, .io_bit,
  .flag_register, .stack_ptr);
`default_nettype wire
